// *** dv/serial_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input  wire logic sck,
  input  wire logic sdo,
  input  wire logic idle_low,
  output logic      sdi,
  output logic      sck_drv
);
  logic [15:0] tx_bits;
  logic [15:0] rx_bits;
  int          tx_n;
  int          rx_n;
  logic        active;
  initial begin
    sdi = 1'h0;
    sck_drv = 1'h1;
    active = 1'h0;
    tx_n = 0;
    rx_n = 0;
    tx_bits = 16'h0000;
    rx_bits = 16'h0000;
  end
  always @(sck) begin
    if (active && sck === idle_low) begin
      sdi <= tx_bits[tx_n[3:0]];
      tx_n++;
    end else if (active) begin
      rx_bits[rx_n[3:0]] = sdo;
      rx_n++;
    end
  end
  // Released line must not keep the last bit, or a stale sample passes
  always @(negedge active) sdi <= ~sdi;
  // slave clock only inside a frame, idle otherwise
  task automatic clock_out(input int n);
    for (int i = 0; i < n; i++) begin
      #160 sck_drv = idle_low;
      #160 sck_drv = ~idle_low;
    end
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`include "sync_serial_function_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sync_serial_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq, sdi, sck_p;
  logic [1:0]  bresp, rresp, rd_r;
  logic [2:0]  pin_lvl;
  logic        float_bit = 1'h0;
  logic        ck_type;
  port_pins_t  pins;
  int          fails, n_tests;
  int          irq_cnt = 0;
  sync_serial_port #(.AW(18), .MASTER_HALF(4)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port4_pin_in(pin_lvl),
    .port4_pin(pins), .transfer_done_irq(irq));
  serial_peer peer (.sck(pin_lvl[1]), .sdo(pin_lvl[2]), .idle_low(ck_type),
    .sdi(sdi), .sck_drv(sck_p));
  assign pin_lvl[0] = pins.oe_n[0] ? sdi : pins.out[0];
  assign pin_lvl[1] = pins.oe_n[1] ? sck_p : pins.out[1];
  assign pin_lvl[2] = pins.oe_n[2] ? float_bit : pins.out[2];
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    float_bit <= ~float_bit;
    if (irq === 1'h1) irq_cnt <= irq_cnt + 1;
  end
  task wrap_up;
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task axi_wr(input logic [15:0] idx, input logic [31:0] d,
              input logic [1:0] er);
    int k;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    if (k == 50) begin fails++; wrap_up(); end
    check(bresp, er);
  endtask
  task rd(input logic [15:0] idx);
    int k;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'h0;
    if (k == 50) begin fails++; wrap_up(); end
  endtask
  task wait_done(input int n0);
    int k;
    for (k = 0; k < 3000 && irq_cnt == n0; k++) @(posedge aclk);
    if (k == 3000) begin fails++; wrap_up(); end
    repeat (3) @(posedge aclk);
    check(irq_cnt, n0 + 1);
    peer.active = 1'h0;
    rd(`IDX_SER_CTL);
    check(rd_d[0], 1'h0);
  endtask
  task cfg(input logic [7:0] dir, input logic [7:0] ck, input logic [7:0] md);
    ck_type = ck[4];
    axi_wr(`IDX_P4_FSL_HI, 32'h07, `RESP_OK);
    axi_wr(`IDX_P4_FSL_LO, 32'h00, `RESP_OK);
    axi_wr(`IDX_P4_DRV_HI, 32'h06, `RESP_OK);
    axi_wr(`IDX_P4_DRV_LO, 32'h06, `RESP_OK);
    axi_wr(`IDX_P4_DIR, {24'h0, dir}, `RESP_OK);
    axi_wr(`IDX_SER_CLK, {24'h0, ck}, `RESP_OK);
    axi_wr(`IDX_SER_MODE, {24'h0, md}, `RESP_OK);
  endtask
  task arm(input logic [15:0] bits);
    peer.tx_bits = bits;
    peer.tx_n = 0;
    peer.rx_n = 0;
    peer.rx_bits = 16'h0000;
    peer.active = 1'h1;
  endtask
  task sc_regs;
    rd(`IDX_SER_MODE);
    check(rd_d, 32'h0);
    axi_wr(`IDX_P4_LATCH, 32'hA5, `RESP_OK);
    rd(`IDX_P4_LATCH);
    check(rd_d, 32'hA5);
    check(pins.in, 3'h5);
    rd(16'hF240);
    check(rd_r, `RESP_ERR);
    axi_wr(16'hF240, 32'h01, `RESP_ERR);
    axi_wr(`IDX_SER_CTL, 32'h01, `RESP_OK);
    rd(`IDX_SER_CTL);
    check(rd_d[0], 1'h0);
  endtask
  task sc_master_tx;
    cfg(8'h01, 8'h00, 8'h04);
    check(pins.out[1], 1'h1);
    check(pins.oe_n, 3'h1);
    axi_wr(`IDX_SER_BUF, 32'hC3, `RESP_OK);
    arm(16'h0000);
    axi_wr(`IDX_SER_CTL, 32'h01, `RESP_OK);
    wait_done(irq_cnt);
    check(peer.rx_bits[7:0], 8'hC3);
    check(peer.rx_n, 8);
  endtask
  task sc_master_rx;
    logic [15:0] v;
    logic [15:0] b;
    v = 16'h9C35;
    for (int i = 0; i < 16; i++) b[i] = v[15 - i];
    cfg(8'h01, 8'h10, 8'h0B);
    check(pins.out[1], 1'h0);
    arm(b);
    axi_wr(`IDX_SER_CTL, 32'h01, `RESP_OK);
    wait_done(irq_cnt);
    check(peer.rx_bits, 16'hFFFF);
    check(peer.rx_n, 16);
    rd(`IDX_SER_BUF);
    check(rd_d, {16'h0, v});
  endtask
  task sc_slave_duplex;
    cfg(8'h03, 8'h06, 8'h06);
    check(pins.oe_n[1], 1'h1);
    axi_wr(`IDX_SER_BUF, 32'h3A, `RESP_OK);
    arm(16'h006D);
    axi_wr(`IDX_SER_CTL, 32'h01, `RESP_OK);
    #7 peer.clock_out(8);
    wait_done(irq_cnt);
    check(peer.rx_bits[7:0], 8'h3A);
    rd(`IDX_SER_BUF);
    check(rd_d, 32'h6D);
  endtask
  task sc_duplex_msb16;
    logic [15:0] v;
    logic [15:0] b;
    logic [15:0] r;
    v = 16'h5A3C;
    for (int i = 0; i < 16; i++) b[i] = v[15 - i];
    cfg(8'h01, 8'h12, 8'h0F);
    axi_wr(`IDX_SER_BUF, 32'hB4E1, `RESP_OK);
    arm(b);
    axi_wr(`IDX_SER_CTL, 32'h01, `RESP_OK);
    wait_done(irq_cnt);
    for (int i = 0; i < 16; i++) r[i] = peer.rx_bits[15 - i];
    check(r, 16'hB4E1);
    check(peer.rx_n, 16);
    rd(`IDX_SER_BUF);
    check(rd_d, {16'h0, v});
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 18'h0;
    araddr = 18'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    ck_type = 1'h0;
    fails = 0;
    n_tests = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    sc_regs;
    sc_master_tx;
    sc_master_rx;
    sc_slave_duplex;
    sc_duplex_msb16;
    wrap_up;
  end
endmodule
`default_nettype wire

// *** hdl/sync_serial_function_defs.svh ***
`ifndef SYNC_SERIAL_DEFS_SVH
`define SYNC_SERIAL_DEFS_SVH
// Register indices; byte address is four times the index
`define IDX_P4_LATCH  16'hF220
`define IDX_P4_DIR    16'hF221
`define IDX_P4_DRV_LO 16'hF222
`define IDX_P4_DRV_HI 16'hF223
`define IDX_P4_FSL_LO 16'hF224
`define IDX_P4_FSL_HI 16'hF225
`define IDX_SER_MODE  16'hF230
`define IDX_SER_CLK   16'hF231
`define IDX_SER_CTL   16'hF232
`define IDX_SER_BUF   16'hF233
// Field positions
`define CTL_RUN       0
`define CK_EXT_A      4'h6
`define CK_EXT_B      4'h7
`define PIN_SIN       0
`define PIN_SCK       1
`define PIN_SOUT      2
// Constants
`define LEN_8         5'h08
`define LEN_16        5'h10
`define RESP_OK       2'h0
`define RESP_ERR      2'h2
`define ZERO_BYTE     8'h00
`endif

// *** hdl/sync_serial_function_pkg.sv ***
package sync_serial_pkg;
  typedef struct packed {
    logic lg;
    logic md_hi;
    logic md_lo;
    logic msb_first;
  } serial_mode_t;
  typedef struct packed {
    logic       idle_low;
    logic [3:0] sel;
  } clock_select_t;
  typedef struct packed {
    logic [2:0] in;
    logic [2:0] out;
    logic [2:0] oe_n;
  } port_pins_t;
  typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_t;
endpackage

// *** hdl/sync_serial_port.sv ***
// Overview of operation
// R1 - Mode bits 1,0 select transmit only
// R2 - Run bit write starts shifting buffer out
// R3 - Transmit word done: pulse irq, clear run
// R4 - Transmit bits leave on data out pin
// R5 - Internal clock means master, external slave
// R6 - Bit order bit picks LSB/MSB first
// R7 - Mode bits 0,1 select receive only
// R8 - Receive starts on run, no buffer write
// R9 - Receive word done: pulse irq, clear run
// R10 - Receive bits sampled from data in pin
// R11 - Receive only drives data out high
// R12 - Mode bits 1,1 select full duplex
// R13 - Duplex run starts, done after word
// R14 - Duplex shifts out and samples together
// R15 - Software selects third function on pins
// R16 - Function select hi 1, lo 0, bits 2-0
// R17 - Master: out pins push-pull, in input
// R18 - Input drive bits and latch free
// R19 - Length bit: 0 eight, 1 sixteen bits
// R20 - Clock type 0 idles high, 1 low
// R21 - No mode change during transfer; mode writes are not blocked while running
// R22 - One bit per clock period, exact count
`include "sync_serial_function_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port #(
  parameter int AW          = 18,
  parameter int MASTER_HALF = 4
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic [2:0]    port4_pin_in,
  output sync_serial_pkg::port_pins_t port4_pin,
  output logic               transfer_done_irq
);
  import sync_serial_pkg::*;

  function automatic logic [15:0] reg_index(input logic [AW-1:0] a);
    reg_index = 16'(a >> 2);
  endfunction

  // Register storage
  logic [7:0]    port4_output_latch;
  logic [7:0]    port4_direction;
  logic [7:0]    port4_drive_control_lo;
  logic [7:0]    port4_drive_control_hi;
  logic [7:0]    port4_function_select_lo;
  logic [7:0]    port4_function_select_hi;
  serial_mode_t  serial_mode_reg_a;
  clock_select_t serial_clock_select_reg;
  logic [15:0]   shift_buffer;
  xfer_state_t   state;

  // Bus slave
  logic          aw_full;
  logic          w_full;
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  wire           wr_go  = aw_full & w_full & ~s_axi_bvalid;
  wire [15:0]    wr_idx = reg_index(wr_addr);
  wire           wr_b0  = wr_go & wr_strb[0];
  wire           wr_b1  = wr_go & wr_strb[1];

  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire wr_hit = wr_idx >= `IDX_P4_LATCH && wr_idx <= `IDX_P4_FSL_HI
             || wr_idx >= `IDX_SER_MODE && wr_idx <= `IDX_SER_BUF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      wr_addr      <= '0;
      wr_data      <= 32'h00000000;
      wr_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OK : `RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [15:0] rd_idx = reg_index(s_axi_araddr);
  wire [15:0] rd_buf = serial_mode_reg_a.lg ? shift_buffer
                     : {`ZERO_BYTE, shift_buffer[7:0]};
  wire        rd_hit;
  wire [15:0] rd_val;
  assign {rd_hit, rd_val} =
      rd_idx == `IDX_P4_LATCH  ? {1'b1, `ZERO_BYTE, port4_output_latch}
    : rd_idx == `IDX_P4_DIR    ? {1'b1, `ZERO_BYTE, port4_direction}
    : rd_idx == `IDX_P4_DRV_LO ? {1'b1, `ZERO_BYTE, port4_drive_control_lo}
    : rd_idx == `IDX_P4_DRV_HI ? {1'b1, `ZERO_BYTE, port4_drive_control_hi}
    : rd_idx == `IDX_P4_FSL_LO ? {1'b1, `ZERO_BYTE, port4_function_select_lo}
    : rd_idx == `IDX_P4_FSL_HI ? {1'b1, `ZERO_BYTE, port4_function_select_hi}
    : rd_idx == `IDX_SER_MODE  ? {1'b1, 12'h000, serial_mode_reg_a}
    : rd_idx == `IDX_SER_CLK   ? {1'b1, 11'h000, serial_clock_select_reg}
    : rd_idx == `IDX_SER_CTL   ? {1'b1, 15'h0000, state == ST_SHIFT}
    : rd_idx == `IDX_SER_BUF   ? {1'b1, rd_buf}
    : {1'b0, 16'h0000};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_val};
      s_axi_rresp  <= rd_hit ? `RESP_OK : `RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin inputs pass two flops; a third stage serves edge finding
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic       sck_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      sck_prev <= 1'b0;
    end else begin
      pin_meta <= port4_pin_in;
      pin_sync <= pin_meta;
      sck_prev <= pin_sync[`PIN_SCK];
    end
  end

  // R16 third function
  wire [2:0] third_fn = port4_function_select_hi[2:0]
                      & ~port4_function_select_lo[2:0];
  // R5 master or slave
  wire is_master = serial_clock_select_reg.sel != `CK_EXT_A
                && serial_clock_select_reg.sel != `CK_EXT_B;
  // R20 idle level
  wire idle_lvl  = ~serial_clock_select_reg.idle_low;
  wire running   = state == ST_SHIFT;
  // R19 word length
  wire [4:0] len = serial_mode_reg_a.lg ? `LEN_16 : `LEN_8;
  wire [4:0] last_bit = len - 5'h01;

  // Master clock divider; held at idle level outside transfers
  logic       mclk;
  logic [15:0] hcnt;
  wire        half_tick = running && is_master
                       && hcnt == 16'(MASTER_HALF - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mclk <= 1'b1;
      hcnt <= 16'h0000;
    end else if (!running) begin
      mclk <= idle_lvl;
      hcnt <= 16'h0000;
    end else begin
      hcnt <= half_tick ? 16'h0000 : hcnt + 16'h0001;
      if (half_tick)
        mclk <= ~mclk;
    end
  end

  wire sck_now  = pin_sync[`PIN_SCK];
  wire s_lead   = sck_prev == idle_lvl && sck_now != idle_lvl;
  wire s_trail  = sck_prev != idle_lvl && sck_now == idle_lvl;
  // R5 edge source
  wire lead  = running && (is_master ? half_tick && mclk == idle_lvl
                                     : s_lead);
  wire trail = running && (is_master ? half_tick && mclk != idle_lvl
                                     : s_trail);

  // R10 sampled data
  wire sin_bit = serial_mode_reg_a.md_lo & pin_sync[`PIN_SIN];
  wire msb     = serial_mode_reg_a.msb_first;
  wire lg      = serial_mode_reg_a.lg;
  // R6 next output bit
  wire tx_bit  = msb ? (lg ? shift_buffer[15] : shift_buffer[7])
                     : shift_buffer[0];
  wire [15:0] sh_msb = {shift_buffer[14:0], sin_bit};
  wire [15:0] sh_lsb = lg ? {sin_bit, shift_buffer[15:1]}
                          : {8'h00, sin_bit, shift_buffer[7:1]};

  logic [4:0] bit_cnt;
  logic       sout_bit;
  // R22 exact count
  wire done = trail && bit_cnt == last_bit;
  wire start = wr_b0 && wr_idx == `IDX_SER_CTL
            && wr_data[`CTL_RUN] && !running
            && (serial_mode_reg_a.md_hi || serial_mode_reg_a.md_lo);
  wire abort = wr_b0 && wr_idx == `IDX_SER_CTL
            && !wr_data[`CTL_RUN] && running;

  // R2 run control
  // R8 start without buffer load
  // R13 duplex start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state             <= ST_IDLE;
      transfer_done_irq <= 1'b0;
    end else begin
      transfer_done_irq <= done;
      case (state)
        ST_IDLE: begin
          if (start)
            state <= ST_SHIFT;
        end
        ST_SHIFT: begin
          // R3 clear run
          // R9 clear run
          if (done || abort)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // R14 shift and sample
  // R22 one bit per period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_buffer <= 16'h0000;
      bit_cnt      <= 5'h00;
      sout_bit     <= 1'b1;
    end else begin
      if (start)
        bit_cnt <= 5'h00;
      else if (trail)
        bit_cnt <= bit_cnt + 5'h01;
      if (lead)
        sout_bit <= tx_bit;
      if (trail)
        shift_buffer <= msb ? sh_msb : sh_lsb;
      else if (!running && wr_idx == `IDX_SER_BUF) begin
        if (wr_b0)
          shift_buffer[7:0] <= wr_data[7:0];
        if (wr_b1)
          shift_buffer[15:8] <= wr_data[15:8];
      end
    end
  end

  // Configuration writes; mode changes mid-transfer are not blocked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port4_output_latch       <= 8'h00;
      port4_direction          <= 8'h00;
      port4_drive_control_lo   <= 8'h00;
      port4_drive_control_hi   <= 8'h00;
      port4_function_select_lo <= 8'h00;
      port4_function_select_hi <= 8'h00;
      serial_mode_reg_a        <= '0;
      serial_clock_select_reg  <= '0;
    end else if (wr_b0) begin
      if (wr_idx == `IDX_P4_LATCH)
        port4_output_latch <= wr_data[7:0];
      else if (wr_idx == `IDX_P4_DIR)
        port4_direction <= wr_data[7:0];
      else if (wr_idx == `IDX_P4_DRV_LO)
        port4_drive_control_lo <= wr_data[7:0];
      else if (wr_idx == `IDX_P4_DRV_HI)
        port4_drive_control_hi <= wr_data[7:0];
      else if (wr_idx == `IDX_P4_FSL_LO)
        port4_function_select_lo <= wr_data[7:0];
      else if (wr_idx == `IDX_P4_FSL_HI)
        port4_function_select_hi <= wr_data[7:0];
      else if (wr_idx == `IDX_SER_MODE)
        serial_mode_reg_a <= wr_data[3:0];
      else if (wr_idx == `IDX_SER_CLK)
        serial_clock_select_reg <= wr_data[4:0];
    end
  end

  // R1 transmit only
  // R7 receive only
  // R12 full duplex
  wire rx_only = ~serial_mode_reg_a.md_hi & serial_mode_reg_a.md_lo;
  // R11 output held high
  wire sout_lvl = rx_only ? 1'b1 : sout_bit;
  // R4 data out pin
  // R17 direction bit drives plain GPIO only
  wire [2:0] fn_out = {sout_lvl, mclk, 1'b1};
  wire [2:0] fn_oe_n = {1'b0, ~is_master, 1'b1};
  assign port4_pin.in   = pin_sync;
  assign port4_pin.out  = (third_fn & fn_out)
                        | (~third_fn & port4_output_latch[2:0]);
  assign port4_pin.oe_n = (third_fn & fn_oe_n)
                        | (~third_fn & port4_direction[2:0]);

  a_done_clears_run: assert property (@(posedge aclk) // R3
    disable iff (!aresetn) done |=> state == ST_IDLE && transfer_done_irq)
    else $error("run not cleared after word");
  a_start_sets_run: assert property (@(posedge aclk) // R2
    disable iff (!aresetn) start |=> running ##1 bit_cnt == 5'h00)
    else $error("start not taken");
  a_rx_only_high: assert property (@(posedge aclk) // R11
    disable iff (!aresetn) rx_only && third_fn[`PIN_SOUT]
    |-> port4_pin.out[`PIN_SOUT])
    else $error("data out not high in receive mode");
  // Clock flop takes a new idle level one cycle after the write
  a_idle_clock: assert property (@(posedge aclk) // R20
    disable iff (!aresetn) !$past(running) && !running
    |-> mclk == $past(idle_lvl))
    else $error("master clock not at idle level");
  a_master_drive: assert property (@(posedge aclk) // R5
    disable iff (!aresetn) third_fn[`PIN_SCK]
    |-> port4_pin.oe_n[`PIN_SCK] == !is_master)
    else $error("clock pin drive wrong for role");
  a_one_bit_step: assert property (@(posedge aclk) // R22
    disable iff (!aresetn) trail && !done
    |=> bit_cnt == $past(bit_cnt) + 5'h01 && running)
    else $error("bit count step wrong");
  a_lsb_order: assert property (@(posedge aclk) // R6
    disable iff (!aresetn) lead && !msb |=> sout_bit == $past(shift_buffer[0]))
    else $error("lsb first order broken");
  a_len_reset: assert property (@(posedge aclk) // R19
    !$past(aresetn) |-> !serial_mode_reg_a.lg && len == `LEN_8)
    else $error("length not eight after reset");
  // Written for the default half period of four cycles
  a_master_period: assert property (@(posedge aclk) // R13
    disable iff (!aresetn) start && is_master
    |=> !lead [*3] ##1 lead)
    else $error("master edge too early");
endmodule
`default_nettype wire
